// ---- dv/sws_host_model.sv ----
// host-side model driving the sleep permission pin of the modem
`timescale 1ns/1ps
module sws_host_model (
  input  wire logic [1:0] mode,
  output wire logic       level,
  output wire logic       driven
);
  // mode: 0 leave pin floating, 1 drive high, 2 drive low

  // -------------------------------------------------------------
  // pin drive
  // -------------------------------------------------------------
  // floating pin shown high, the worst case: only the pull-down can permit sleep
  assign driven = (mode != 2'h0);
  assign level  = (mode != 2'h2);
endmodule // sws_host_model

// ---- dv/sws_top_tb.sv ----
// self-checking testbench of the sleep/wake signalling block
`timescale 1ns/1ps
module sws_top_tb;
  localparam int unsigned HOLD  = 20;
  localparam int unsigned PULSE = 16;

  logic                clk           = 1'b0;
  logic                rst           = 1'b1;
  logic [1:0]          host_mode     = 2'h2;
  logic                sleep_req     = 1'b0;
  logic                wake_host_req = 1'b0;
  logic                power_down    = 1'b0;
  wire logic           perm_level;
  wire logic           perm_driven;
  logic                host_wake;
  logic                sleep_status;
  sws_pkg::sws_aux_s   aux;
  sws_pkg::sws_state_e state;
  int                  miscompares   = 0;
  int                  num_checks    = 0;
  int                  n;

  always #12.5 clk = ~clk;

  sws_host_model u_sws_host_model (.mode(host_mode), .level(perm_level),
                                   .driven(perm_driven));

  sws_top #(.WAKE_HOLD_CYC(HOLD), .HOST_PULSE_CYC(PULSE)) u_sws_top (
    .clk(clk), .rst(rst), .sleep_perm_level(perm_level), .sleep_perm_driven(perm_driven),
    .sleep_req(sleep_req), .wake_host_req(wake_host_req), .power_down(power_down),
    .host_wake(host_wake), .sleep_status(sleep_status), .aux_supply_out(aux),
    .power_state(state));

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  task chk_mode(input sws_pkg::sws_state_e st);
    chk({30'h0, state}, {30'h0, st});
    chk({31'h0, sleep_status}, {31'h0, st == sws_pkg::ST_AWAKE});
    chk({30'h0, aux}, {30'h0, (st == sws_pkg::ST_AWAKE) ? sws_pkg::AUX_AWAKE :
        (st == sws_pkg::ST_SLEEP) ? sws_pkg::AUX_SLEEP : sws_pkg::AUX_OFF});
  endtask

  task give_verdict;
    if (miscompares == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task t_perm_blocks;
    host_mode = 2'h1;
    sleep_req = 1'b1;
    cyc(5);
    chk_mode(sws_pkg::ST_AWAKE);
    sleep_req = 1'b0;
  endtask

  task t_float_sleep;
    host_mode = 2'h0;
    sleep_req = 1'b1;
    cyc(1);
    chk_mode(sws_pkg::ST_SLEEP);
    sleep_req = 1'b0;
    cyc(3);
    chk_mode(sws_pkg::ST_SLEEP);
  endtask

  task t_hold_wake;
    // a drop halfway must restart the hold count
    host_mode = 2'h1;
    cyc(HOLD / 2);
    host_mode = 2'h2;
    cyc(1);
    host_mode = 2'h1;
    cyc(HOLD - 1);
    chk_mode(sws_pkg::ST_SLEEP);
    cyc(1);
    chk_mode(sws_pkg::ST_AWAKE);
    host_mode = 2'h2;
  endtask

  task t_pulse;
    wake_host_req = 1'b1;
    sleep_req     = 1'b1;
    cyc(1);
    wake_host_req = 1'b0;
    chk_mode(sws_pkg::ST_AWAKE);
    n = 0;
    while (host_wake === 1'b1 && n < 100)
    begin
      n++;
      wake_host_req = (n == 5);
      chk_mode(sws_pkg::ST_AWAKE);
      cyc(1);
    end
    chk(n, PULSE);
    chk({31'h0, host_wake}, 32'h0);
    cyc(1);
    chk_mode(sws_pkg::ST_SLEEP);
    sleep_req = 1'b0;
  endtask

  task t_power_down;
    wake_host_req = 1'b1;
    cyc(1);
    chk_mode(sws_pkg::ST_AWAKE);
    wake_host_req = 1'b0;
    cyc(3);
    chk({31'h0, host_wake}, 32'h1);
    power_down = 1'b1;
    cyc(1);
    chk_mode(sws_pkg::ST_OFF);
    chk({31'h0, host_wake}, 32'h0);
    cyc(3);
    chk_mode(sws_pkg::ST_OFF);
    power_down = 1'b0;
    cyc(1);
    chk_mode(sws_pkg::ST_AWAKE);
    cyc(1);
    chk_mode(sws_pkg::ST_AWAKE);
    chk({31'h0, host_wake}, 32'h0);
  endtask

  // -------------------------------------------------------------
  // main sequence and watchdog
  // -------------------------------------------------------------
  initial
  begin
    cyc(3);
    rst = 1'b0;
    chk_mode(sws_pkg::ST_AWAKE);
    chk({31'h0, host_wake}, 32'h0);
    t_perm_blocks();
    t_float_sleep();
    t_hold_wake();
    t_pulse();
    t_power_down();
    give_verdict();
  end

  // whole run needs about 70 cycles
  initial
  begin
    repeat (2000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
endmodule // sws_top_tb

// ---- hdl/sws_pkg.sv ----
// constants and types shared by the sleep/wake signalling block
package sws_pkg;

  // --------------------------------------------------------------
  // clock and timing
  // --------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned WAKE_HOLD_MS  = 1000;
  localparam int unsigned HOST_PULSE_MS = 1000;
  // least time: round down, at least one cycle
  localparam int unsigned WAKE_HOLD_CYC =
    (CLK_HZ / MS_PER_S * WAKE_HOLD_MS + 0) > 0 ? CLK_HZ / MS_PER_S * WAKE_HOLD_MS : 1;
  // pulse length: round down, at least one cycle
  localparam int unsigned HOST_PULSE_CYC =
    (CLK_HZ / MS_PER_S * HOST_PULSE_MS) > 0 ? CLK_HZ / MS_PER_S * HOST_PULSE_MS : 1;
  localparam int unsigned CNT_W         = 26;

  // --------------------------------------------------------------
  // power states and auxiliary supply control
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_AWAKE,
    ST_SLEEP,
    ST_OFF
  } sws_state_e;

  typedef struct packed {
    logic enable;
    logic low_power;
  } sws_aux_s;

  localparam sws_state_e STATE_RST      = ST_AWAKE;
  localparam logic       HOST_WAKE_RST  = 1'b0;
  localparam logic       SLEEP_STAT_RST = 1'b1;
  localparam sws_aux_s   AUX_RST        = '{enable: 1'b1, low_power: 1'b0};
  localparam sws_aux_s   AUX_AWAKE      = '{enable: 1'b1, low_power: 1'b0};
  localparam sws_aux_s   AUX_SLEEP      = '{enable: 1'b1, low_power: 1'b1};
  localparam sws_aux_s   AUX_OFF        = '{enable: 1'b0, low_power: 1'b0};

endpackage

// ---- hdl/sws_timer.sv ----
// run-length timer: flags the cycle in which run has lasted LIMIT cycles
`timescale 1ns/1ps
module sws_timer #(
  parameter int unsigned            CNT_W = 26,
  parameter logic [CNT_W-1:0]       LIMIT = CNT_W'(sws_pkg::WAKE_HOLD_CYC)
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 run,
  output logic                      done
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  // --------------------------------------------------------------
  // counter
  // --------------------------------------------------------------
  // saturates so a held run keeps done asserted
  always_comb
  begin
    cnt_d = cnt_q;
    if (!run)
      cnt_d = '0;
    else if (cnt_q != LIMIT - 1'b1)
      cnt_d = cnt_q + 1'b1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  assign done = run && (cnt_q == LIMIT - 1'b1);

endmodule // sws_timer

// ---- hdl/sws_top.sv ----
// sleep/wake handshake and auxiliary supply gating of the modem side
//
// Function
// - host holding sleep permission high keeps the device awake
// - undriven sleep permission input reads low through internal pull-down
// - permission held high one second wakes a sleeping device
// - host wake output is one high pulse of exactly one second, cut short by power-down
// - host wake output stays low otherwise and after reset
// - sleep status output is high while awake
// - sleep status output is low while asleep
// - auxiliary supply goes to low-consumption mode in sleep
// - auxiliary supply is disabled in power-down
`timescale 1ns/1ps
module sws_top #(
  parameter int unsigned WAKE_HOLD_CYC  = sws_pkg::WAKE_HOLD_CYC,
  parameter int unsigned HOST_PULSE_CYC = sws_pkg::HOST_PULSE_CYC
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             sleep_perm_level,
  input  wire logic             sleep_perm_driven,
  input  wire logic             sleep_req,
  input  wire logic             wake_host_req,
  input  wire logic             power_down,
  output logic                  host_wake,
  output logic                  sleep_status,
  output sws_pkg::sws_aux_s     aux_supply_out,
  output sws_pkg::sws_state_e   power_state
);

  localparam int unsigned   CW       = sws_pkg::CNT_W;
  localparam logic [CW-1:0] HOLD_LIM = CW'(WAKE_HOLD_CYC);
  localparam logic [CW-1:0] PULS_LIM = CW'(HOST_PULSE_CYC);

  sws_pkg::sws_state_e state_q;
  sws_pkg::sws_state_e state_d;
  sws_pkg::sws_aux_s   aux_q;
  sws_pkg::sws_aux_s   aux_d;
  logic                status_q;
  logic                status_d;
  logic                pulse_q;
  logic                pulse_d;
  logic                perm;
  logic                hold_run;
  logic                hold_done;
  logic                pulse_done;
  logic                sleep_ok;

  // --------------------------------------------------------------
  // sleep permission input
  // --------------------------------------------------------------
  // a floating pin resolves low: sleep permitted by default
  assign perm = sleep_perm_driven && sleep_perm_level;

  // --------------------------------------------------------------
  // one-second timers
  // --------------------------------------------------------------
  // any drop of permission restarts the hold from zero
  assign hold_run = (state_q == sws_pkg::ST_SLEEP) && perm;

  sws_timer #(
    .CNT_W (CW),
    .LIMIT (HOLD_LIM)
  ) u_hold (
    .clk  (clk),
    .rst  (rst),
    .run  (hold_run),
    .done (hold_done)
  );

  sws_timer #(
    .CNT_W (CW),
    .LIMIT (PULS_LIM)
  ) u_pulse (
    .clk  (clk),
    .rst  (rst),
    .run  (pulse_q),
    .done (pulse_done)
  );

  // --------------------------------------------------------------
  // host wake pulse
  // --------------------------------------------------------------
  // requests during a pulse or in power-down are dropped, not queued
  always_comb
  begin
    pulse_d = pulse_q;
    if (pulse_q && pulse_done)
      pulse_d = 1'b0;
    else if (!pulse_q && wake_host_req && !power_down && state_q != sws_pkg::ST_OFF)
      pulse_d = 1'b1;
    if (power_down)
      pulse_d = 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pulse_q <= sws_pkg::HOST_WAKE_RST;
    else
      pulse_q <= pulse_d;
  end

  // --------------------------------------------------------------
  // power state
  // --------------------------------------------------------------
  // waking the host also wakes the device, so the pulse never overlaps sleep
  assign sleep_ok = sleep_req && !perm && !pulse_q && !wake_host_req;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      sws_pkg::ST_AWAKE:
        if (sleep_ok)
          state_d = sws_pkg::ST_SLEEP;
      sws_pkg::ST_SLEEP:
        if (hold_done || wake_host_req)
          state_d = sws_pkg::ST_AWAKE;
      sws_pkg::ST_OFF:
        state_d = sws_pkg::ST_AWAKE;
      default:
        state_d = sws_pkg::ST_AWAKE;
    endcase
    if (power_down)
      state_d = sws_pkg::ST_OFF;
  end

  always_comb
  begin
    status_d = 1'b0;
    aux_d    = sws_pkg::AUX_AWAKE;
    unique case (state_d)
      sws_pkg::ST_AWAKE:
      begin
        status_d = 1'b1;
        aux_d    = sws_pkg::AUX_AWAKE;
      end
      sws_pkg::ST_SLEEP:
      begin
        status_d = 1'b0;
        aux_d    = sws_pkg::AUX_SLEEP;
      end
      sws_pkg::ST_OFF:
      begin
        status_d = 1'b0;
        aux_d    = sws_pkg::AUX_OFF;
      end
      default:
      begin
        status_d = 1'b0;
        aux_d    = sws_pkg::AUX_OFF;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q  <= sws_pkg::STATE_RST;
      status_q <= sws_pkg::SLEEP_STAT_RST;
      aux_q    <= sws_pkg::AUX_RST;
    end
    else
    begin
      state_q  <= state_d;
      status_q <= status_d;
      aux_q    <= aux_d;
    end
  end

  assign host_wake      = pulse_q;
  assign sleep_status   = status_q;
  assign aux_supply_out = aux_q;
  assign power_state    = state_q;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  logic [CW-1:0] chk_hold_q;
  logic [CW-1:0] chk_puls_q;

  // independent cycle counts, kept apart from the timers they check
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      chk_hold_q <= '0;
      chk_puls_q <= '0;
    end
    else
    begin
      chk_hold_q <= hold_run ? chk_hold_q + 1'b1 : '0;
      chk_puls_q <= pulse_q ? chk_puls_q + 1'b1 : '0;
    end
  end

  property p_perm_blocks_sleep;
    @(posedge clk) disable iff (rst)
    (state_q == sws_pkg::ST_AWAKE && perm) |=> (state_q != sws_pkg::ST_SLEEP);
  endproperty
  a_perm_blocks_sleep: assert property (p_perm_blocks_sleep)
    else $error("entered sleep while sleep permission was high");

  property p_pulldown;
    @(posedge clk) disable iff (rst)
    (!sleep_perm_driven && state_q == sws_pkg::ST_SLEEP) |-> !hold_run;
  endproperty
  a_pulldown: assert property (p_pulldown)
    else $error("undriven permission input did not read low");

  property p_hold_wakes;
    @(posedge clk) disable iff (rst)
    (hold_run && chk_hold_q == HOLD_LIM - 1'b1 && !power_down)
      |=> (state_q == sws_pkg::ST_AWAKE);
  endproperty
  a_hold_wakes: assert property (p_hold_wakes)
    else $error("one second of permission did not wake the device");

  property p_no_early_wake;
    @(posedge clk) disable iff (rst)
    (state_q == sws_pkg::ST_SLEEP && !wake_host_req && !power_down
      && chk_hold_q < HOLD_LIM - 1'b1) |=> (state_q == sws_pkg::ST_SLEEP);
  endproperty
  a_no_early_wake: assert property (p_no_early_wake)
    else $error("device woke before permission was held one second");

  property p_pulse_len;
    @(posedge clk) disable iff (rst)
    $fell(host_wake) && !$past(power_down) |-> ($past(chk_puls_q) == PULS_LIM - 1'b1);
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("host wake pulse length is not one second");

  property p_pulse_max;
    @(posedge clk) disable iff (rst)
    host_wake |-> (chk_puls_q < PULS_LIM);
  endproperty
  a_pulse_max: assert property (p_pulse_max)
    else $error("host wake pulse ran past one second");

  property p_wake_cause;
    @(posedge clk) disable iff (rst)
    $rose(host_wake) |-> $past(wake_host_req);
  endproperty
  a_wake_cause: assert property (p_wake_cause)
    else $error("host wake rose without a request");

  property p_status_awake;
    @(posedge clk) disable iff (rst)
    (state_q == sws_pkg::ST_AWAKE) |-> sleep_status;
  endproperty
  a_status_awake: assert property (p_status_awake)
    else $error("sleep status low while awake");

  property p_status_sleep;
    @(posedge clk) disable iff (rst)
    (state_q == sws_pkg::ST_SLEEP) |-> !sleep_status && aux_supply_out.low_power;
  endproperty
  a_status_sleep: assert property (p_status_sleep)
    else $error("sleep status or supply mode wrong while asleep");

  property p_aux_off;
    @(posedge clk) disable iff (rst)
    power_down |=> (!aux_supply_out.enable && state_q == sws_pkg::ST_OFF);
  endproperty
  a_aux_off: assert property (p_aux_off)
    else $error("auxiliary supply still enabled in power-down");

  property p_sleep_entry;
    @(posedge clk) disable iff (rst)
    (state_q == sws_pkg::ST_AWAKE && (host_wake || wake_host_req))
      |=> (state_q != sws_pkg::ST_SLEEP);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("entered sleep during a host wake pulse");

endmodule // sws_top
